// ==== src/pvw_pkg.sv ====
package pvw_pkg;
  // register byte offsets
  localparam logic [11:0] CTL_OFS = 12'h1a0;
  localparam logic [11:0] BASE_OFS = 12'h1a4;
  localparam logic [11:0] BOUND_OFS = 12'h1a8;
  localparam logic [11:0] XOFS_OFS = 12'h1ac;
  localparam logic [11:0] STAT_OFS = 12'h1b0;
  // control field positions
  localparam int EN_BIT = 31;
  localparam int POSTED_WRITE_ALLOW_BIT = 30;
  localparam int VDW_LSB = 22;
  localparam int VAS_LSB = 16;
  localparam int PGM_BIT = 14;
  localparam int SUPER_BIT = 12;
  localparam int VCT_BIT = 8;
  localparam int LAS_BIT = 0;
  // writable bits and values after reset
  localparam logic [31:0] CTL_MASK = 32'hc0c7_5101;
  localparam logic [31:0] CTL_RESET = 32'h0080_0000;
  localparam logic [31:0] ADDR_MASK = 32'hffff_f000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  // 4 KB granule: address bits below this are not compared
  localparam int PAGE_LSB = 12;
  localparam int CNT_W = 16;
  localparam int BUF_DEPTH = 2;
  localparam logic [1:0] BUF_LVL_RESET = 2'h0;

  typedef enum logic [1:0] {
    PVW_W8 = 2'h0,
    PVW_W16 = 2'h1,
    PVW_W32 = 2'h2,
    PVW_W64 = 2'h3
  } pvw_width_t;

  typedef enum logic [2:0] {
    PVW_A16 = 3'h0,
    PVW_A24 = 3'h1,
    PVW_A32 = 3'h2,
    PVW_RSV3 = 3'h3,
    PVW_RSV4 = 3'h4,
    PVW_CFG = 3'h5,
    PVW_USER1 = 3'h6,
    PVW_USER2 = 3'h7
  } pvw_space_t;

  // width of one queued transfer descriptor
  localparam int DESC_W = 43;
endpackage : pvw_pkg

// ==== src/pvw_win_cmp.sv ====
`timescale 1ns/100ps
module pvw_win_cmp #(
  parameter int LSB = 12
) (
  input wire logic [31:0] addr_i,
  input wire logic [31:0] base_i,
  input wire logic [31:0] bound_i,
  output logic hit_o
);
  logic above_base;
  logic below_bound;
  logic no_bound;

  always_comb begin
    above_base = addr_i[31:LSB] >= base_i[31:LSB];
    below_bound = addr_i[31:LSB] < bound_i[31:LSB];
    no_bound = bound_i[31:LSB] == '0;
    hit_o = above_base && (below_bound || no_bound);
  end
endmodule : pvw_win_cmp

// ==== src/pvw_buf.sv ====
`timescale 1ns/100ps
module pvw_buf #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [1:0] level_o
);
  logic [W-1:0] mem [2];
  logic [W-1:0] next_mem [2];
  logic wr_idx;
  logic next_wr_idx;
  logic rd_idx;
  logic next_rd_idx;
  logic [1:0] level;
  logic [1:0] next_level;
  logic push;
  logic pop;

  always_comb begin
    in_ready_o = level != 2'h2;
    out_valid_o = level != 2'h0;
    out_data_o = mem[rd_idx];
    level_o = level;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_mem = mem;
    next_wr_idx = wr_idx;
    next_rd_idx = rd_idx;
    next_level = level;
    if (push) begin
      next_mem[wr_idx] = in_data_i;
      next_wr_idx = !wr_idx;
    end
    if (pop) begin
      next_rd_idx = !rd_idx;
    end
    if (push && !pop) begin
      next_level = level + 2'h1;
    end else if (pop && !push) begin
      next_level = level - 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_idx <= 1'b0;
      rd_idx <= 1'b0;
      level <= pvw_pkg::BUF_LVL_RESET;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      wr_idx <= next_wr_idx;
      rd_idx <= next_rd_idx;
      level <= next_level;
      mem <= next_mem;
    end
  end
endmodule : pvw_buf

// ==== src/pvw_window.sv ====
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
// Functional notes
// - the width code limits transfers to 00 byte, 01 16-bit, 10 32-bit, 11 64-bit and resets to 10.
// - block_cycle_select at 0 forbids block transfers and at 1 permits them.
// - pci_space_select at 0 answers PCI memory space and at 1 PCI I/O space.
// - block_cycle_select counts only for A24 or A32 with an 8, 16 or 32-bit width code.
// - A24 or A32 with the 64-bit code may use multiplexed block transfers whatever block_cycle_select says.
// - in PCI I/O space posted_write_allow is ignored and every transfer is coupled.
// - window_base bits 31 to 12 are the lowest decoded address.
// - an address is claimed only when at or above the base and, for a nonzero bound, below the bound.
// - a bound of zero claims everything at or above the base.
// - base and bound compare only address bits 31 to 12.
// - outgoing address bits 31 to 12 are PCI bits 31 to 12 plus address_offset bits 31 to 12.
module pvw_window (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pci_valid_i,
  output logic pci_ready_o,
  output logic pci_claim_o,
  input wire logic [31:0] pci_addr_i,
  input wire logic pci_io_i,
  input wire logic pci_write_i,
  output logic vme_valid_o,
  input wire logic vme_ready_i,
  output logic [31:0] vme_addr_o,
  output logic [2:0] vme_space_o,
  output logic [1:0] vme_width_o,
  output logic vme_block_o,
  output logic vme_mblt_o,
  output logic vme_program_o,
  output logic vme_super_o,
  output logic vme_posted_o,
  output logic vme_write_o
);
  // software-visible state
  logic [31:0] image4_control;
  logic [31:0] next_image4_control;
  logic [31:0] image4_base;
  logic [31:0] next_image4_base;
  logic [31:0] image4_bound;
  logic [31:0] next_image4_bound;
  logic [31:0] image4_offset;
  logic [31:0] next_image4_offset;
  logic [pvw_pkg::CNT_W-1:0] claim_cnt;
  logic [pvw_pkg::CNT_W-1:0] next_claim_cnt;
  logic [pvw_pkg::CNT_W-1:0] miss_cnt;
  logic [pvw_pkg::CNT_W-1:0] next_miss_cnt;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // decoded control fields
  logic window_enable;
  logic posted_write_allow;
  logic [1:0] max_data_width;
  logic [2:0] vme_space_select;
  logic program_data_select;
  logic super_select;
  logic block_cycle_select;
  logic pci_space_select;

  // decode path
  logic range_hit;
  logic space_legal;
  logic long_space;
  logic hit;
  logic take;
  logic [31:0] xlat_addr;
  logic blk;
  logic mblt;
  logic posted;
  logic [pvw_pkg::DESC_W-1:0] desc_in;
  logic [pvw_pkg::DESC_W-1:0] desc_out;
  logic buf_in_ready;
  logic [1:0] buf_level;

  // bus helpers
  logic bus_req;
  logic bus_wr;
  logic [31:0] byte_mask;
  logic [31:0] stat_word;

  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [31:0] lanes,
    input logic [31:0] keep
  );
    logic [31:0] m;
    m = lanes & keep;
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  always_comb begin
    window_enable = image4_control[pvw_pkg::EN_BIT];
    posted_write_allow = image4_control[pvw_pkg::POSTED_WRITE_ALLOW_BIT];
    max_data_width = image4_control[pvw_pkg::VDW_LSB +: 2];
    vme_space_select = image4_control[pvw_pkg::VAS_LSB +: 3];
    program_data_select = image4_control[pvw_pkg::PGM_BIT];
    super_select = image4_control[pvw_pkg::SUPER_BIT];
    block_cycle_select = image4_control[pvw_pkg::VCT_BIT];
    pci_space_select = image4_control[pvw_pkg::LAS_BIT];
  end

  pvw_win_cmp #(
    .LSB(pvw_pkg::PAGE_LSB)
  ) u_cmp (
    .addr_i(pci_addr_i),
    .base_i(image4_base),
    .bound_i(image4_bound),
    .hit_o(range_hit)
  );

  always_comb begin
    // reserved space codes never reach the far side
    space_legal = (vme_space_select != pvw_pkg::PVW_RSV3) &&
                  (vme_space_select != pvw_pkg::PVW_RSV4);
    long_space = (vme_space_select == pvw_pkg::PVW_A24) ||
                 (vme_space_select == pvw_pkg::PVW_A32);
    hit = window_enable &&
          (pci_io_i == pci_space_select) &&
          space_legal && range_hit;
    xlat_addr[31:pvw_pkg::PAGE_LSB] =
      pci_addr_i[31:pvw_pkg::PAGE_LSB] +
      image4_offset[31:pvw_pkg::PAGE_LSB];
    xlat_addr[pvw_pkg::PAGE_LSB-1:0] = pci_addr_i[pvw_pkg::PAGE_LSB-1:0];
    blk = long_space && block_cycle_select &&
          (max_data_width != pvw_pkg::PVW_W64);
    mblt = long_space && (max_data_width == pvw_pkg::PVW_W64);
    // i/o space is always coupled, the posted bit is a don't-care there
    posted = posted_write_allow && !pci_space_select && pci_write_i;
    desc_in = {xlat_addr, vme_space_select, max_data_width, blk, mblt,
               program_data_select, super_select, posted, pci_write_i};
  end

  // misses are accepted and dropped at once; a hit waits for buffer room,
  // so a stalled far side holds the initiator rather than losing a word
  always_comb begin
    pci_ready_o = buf_in_ready || !hit;
    pci_claim_o = pci_valid_i && hit;
    take = pci_valid_i && pci_ready_o;
  end

  pvw_buf #(
    .W(pvw_pkg::DESC_W)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(pci_valid_i && hit),
    .in_ready_o(buf_in_ready),
    .in_data_i(desc_in),
    .out_valid_o(vme_valid_o),
    .out_ready_i(vme_ready_i),
    .out_data_o(desc_out),
    .level_o(buf_level)
  );

  always_comb begin
    vme_addr_o = desc_out[42:11];
    vme_space_o = desc_out[10:8];
    vme_width_o = desc_out[7:6];
    vme_block_o = desc_out[5];
    vme_mblt_o = desc_out[4];
    vme_program_o = desc_out[3];
    vme_super_o = desc_out[2];
    vme_posted_o = desc_out[1];
    vme_write_o = desc_out[0];
  end

  // classic wishbone slave, one wait state, ack always follows a request
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !ack;
    bus_wr = bus_req && wb_we_i;
    byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    stat_word = {miss_cnt, claim_cnt};
    next_ack = bus_req;
    next_image4_control = image4_control;
    next_image4_base = image4_base;
    next_image4_bound = image4_bound;
    next_image4_offset = image4_offset;
    next_claim_cnt = claim_cnt;
    next_miss_cnt = miss_cnt;
    next_rdata = '0;
    if (take && hit && claim_cnt != '1) begin
      next_claim_cnt = claim_cnt + 1'b1;
    end
    if (take && !hit && miss_cnt != '1) begin
      next_miss_cnt = miss_cnt + 1'b1;
    end
    if (bus_req) begin
      unique case (wb_adr_i)
        pvw_pkg::CTL_OFS: begin
          next_rdata = image4_control;
          if (bus_wr) begin
            next_image4_control = merge(image4_control, wb_dat_i,
                                        byte_mask, pvw_pkg::CTL_MASK);
          end
        end
        pvw_pkg::BASE_OFS: begin
          next_rdata = image4_base;
          if (bus_wr) begin
            next_image4_base = merge(image4_base, wb_dat_i,
                                     byte_mask, pvw_pkg::ADDR_MASK);
          end
        end
        pvw_pkg::BOUND_OFS: begin
          next_rdata = image4_bound;
          if (bus_wr) begin
            next_image4_bound = merge(image4_bound, wb_dat_i,
                                      byte_mask, pvw_pkg::ADDR_MASK);
          end
        end
        pvw_pkg::XOFS_OFS: begin
          next_rdata = image4_offset;
          if (bus_wr) begin
            next_image4_offset = merge(image4_offset, wb_dat_i,
                                       byte_mask, pvw_pkg::ADDR_MASK);
          end
        end
        pvw_pkg::STAT_OFS: begin
          next_rdata = stat_word;
          // a write clears the counter halves whose lanes are selected
          if (bus_wr && (wb_sel_i[1] || wb_sel_i[0])) begin
            next_claim_cnt = '0;
          end
          if (bus_wr && (wb_sel_i[3] || wb_sel_i[2])) begin
            next_miss_cnt = '0;
          end
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  always_comb begin
    wb_ack_o = ack;
    wb_dat_o = rdata;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      image4_control <= pvw_pkg::CTL_RESET;
      image4_base <= pvw_pkg::ADDR_RESET;
      image4_bound <= pvw_pkg::ADDR_RESET;
      image4_offset <= pvw_pkg::ADDR_RESET;
      claim_cnt <= pvw_pkg::STAT_RESET[15:0];
      miss_cnt <= pvw_pkg::STAT_RESET[31:16];
      ack <= 1'b0;
      rdata <= pvw_pkg::STAT_RESET;
    end else begin
      image4_control <= next_image4_control;
      image4_base <= next_image4_base;
      image4_bound <= next_image4_bound;
      image4_offset <= next_image4_offset;
      claim_cnt <= next_claim_cnt;
      miss_cnt <= next_miss_cnt;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end
endmodule : pvw_window

// ==== verification/pvw_pci_init.sv ====
`timescale 1ns/100ps
module pvw_pci_init (
  input wire logic clk_i,
  input wire logic pci_ready_i,
  input wire logic pci_claim_i,
  output logic pci_valid_o,
  output logic [31:0] pci_addr_o,
  output logic pci_io_o,
  output logic pci_write_o
);
  logic rdy_q;
  logic cl_q;
  initial begin
    pci_valid_o = 1'h0;
    pci_addr_o = 32'h0000_0000;
    pci_io_o = 1'h0;
    pci_write_o = 1'h0;
  end
  // mid-cycle copy is what the next rising edge samples, free of races
  always @(negedge clk_i) begin
    rdy_q = pci_ready_i;
    cl_q = pci_claim_i;
  end
  task automatic send(input logic [31:0] a, input logic io,
      input logic wr, output logic cl);
    @(posedge clk_i);
    pci_valid_o <= 1'h1;
    pci_addr_o <= a;
    pci_io_o <= io;
    pci_write_o <= wr;
    // only the bench watchdog ends a stall
    do begin
      @(posedge clk_i);
    end while (!rdy_q);
    cl = cl_q;
    pci_valid_o <= 1'h0;
    // released address and io lines must not keep showing the old request; the write line keeps its value
    pci_addr_o <= ~a;
    pci_io_o <= ~io;
  endtask : send
endmodule : pvw_pci_init

// ==== verification/pvw_window_props.sv ====
`timescale 1ns/100ps
module pvw_window_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic pci_valid_i,
  input wire logic pci_ready_o,
  input wire logic pci_claim_o,
  input wire logic [31:0] pci_addr_i,
  input wire logic pci_io_i,
  input wire logic vme_valid_o,
  input wire logic vme_ready_i,
  input wire logic [31:0] vme_addr_o,
  input wire logic [2:0] vme_space_o,
  input wire logic [1:0] vme_width_o,
  input wire logic vme_block_o,
  input wire logic vme_mblt_o,
  input wire logic vme_posted_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_push_empty;
    pci_valid_i && pci_ready_o && pci_claim_o && !vme_valid_o;
  endsequence
  property p_ack;
    s_take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_miss;
    pci_valid_i && !pci_claim_o |-> pci_ready_o;
  endproperty
  property p_io;
    s_push_empty ##0 pci_io_i |=> vme_valid_o && !vme_posted_o;
  endproperty
  property p_low;
    s_push_empty |=> vme_addr_o[11:0] == $past(pci_addr_i[11:0]);
  endproperty
  property p_hold;
    vme_valid_o && !vme_ready_i |=> vme_valid_o && $stable(vme_addr_o);
  endproperty
  property p_mblt;
    vme_valid_o && vme_mblt_o |->
      vme_width_o == 2'h3 && vme_space_o inside {3'h1, 3'h2};
  endproperty
  property p_block;
    vme_valid_o && vme_block_o |->
      vme_width_o != 2'h3 && vme_space_o inside {3'h1, 3'h2};
  endproperty
  property p_space;
    vme_valid_o |-> !(vme_space_o inside {3'h3, 3'h4});
  endproperty
  // a stall is only legal while the buffer holds something
  property p_full;
    pci_claim_o && !pci_ready_o |-> vme_valid_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  a_miss: assert property (p_miss) else $error("miss stalled");
  a_io: assert property (p_io) else $error("io posted");
  a_low: assert property (p_low) else $error("low bits moved");
  a_hold: assert property (p_hold) else $error("entry lost");
  a_mblt: assert property (p_mblt) else $error("bad mblt");
  a_block: assert property (p_block) else $error("bad block");
  a_full: assert property (p_full) else $error("stall when empty");
  a_space: assert property (p_space) else $error("reserved space");
endmodule : pvw_window_chk
bind pvw_window pvw_window_chk pvw_window_chk_i (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pci_valid_i, .pci_ready_o,
  .pci_claim_o, .pci_addr_i, .pci_io_i, .vme_valid_o, .vme_ready_i,
  .vme_addr_o, .vme_space_o, .vme_width_o, .vme_block_o, .vme_mblt_o,
  .vme_posted_o);

// ==== verification/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cl, ack_q;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, pci_addr_i, vme_addr_o, dq;
  logic pci_valid_i, pci_ready_o, pci_claim_o, pci_io_i, pci_write_i;
  logic vme_valid_o, vme_ready_i, vme_block_o, vme_mblt_o, vme_program_o;
  logic vme_super_o, vme_posted_o, vme_write_o;
  logic [2:0] vme_space_o;
  logic [1:0] vme_width_o;
  int error_cnt, compares;
  pvw_window pvw_window_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pci_valid_i,
    .pci_ready_o, .pci_claim_o, .pci_addr_i, .pci_io_i, .pci_write_i,
    .vme_valid_o, .vme_ready_i, .vme_addr_o, .vme_space_o, .vme_width_o,
    .vme_block_o, .vme_mblt_o, .vme_program_o, .vme_super_o,
    .vme_posted_o, .vme_write_o);
  pvw_pci_init pvw_pci_init_i (.clk_i, .pci_ready_i(pci_ready_o),
    .pci_claim_i(pci_claim_o), .pci_valid_o(pci_valid_i),
    .pci_addr_o(pci_addr_i), .pci_io_o(pci_io_i),
    .pci_write_o(pci_write_i));
  initial begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  always @(negedge clk_i) begin
    ack_q = wb_ack_o;
    dq = wb_dat_o;
  end
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (!ack_q);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0000_0000);
    chk(dq, e);
  endtask : rd
  task automatic s(input logic [31:0] a, input logic io, input logic wr,
      input logic ecl);
    logic c;
    pvw_pci_init_i.send(a, io, wr, c);
    chk({31'h0, c}, {31'h0, ecl});
  endtask : s
  // attribute word: space, width, block, mblt, program, super, posted, write
  task automatic pop(input logic [31:0] ea, input logic [31:0] eat);
    do begin
      @(negedge clk_i);
    end while (!vme_valid_o);
    chk(vme_addr_o, ea);
    chk({21'h0, vme_space_o, vme_width_o, vme_block_o, vme_mblt_o,
      vme_program_o, vme_super_o, vme_posted_o, vme_write_o}, eat);
    @(posedge clk_i);
    vme_ready_i <= 1'h1;
    @(posedge clk_i);
    vme_ready_i <= 1'h0;
  endtask : pop
  initial begin
    #(100 * 5000);
    error_cnt++;
    print_verdict();
  end
  initial begin
    rst_i = 1'h1;
    {wb_cyc_i, wb_stb_i, wb_we_i, vme_ready_i} = 4'h0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0000_0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(pvw_pkg::CTL_OFS, pvw_pkg::CTL_RESET);
    rd(pvw_pkg::BOUND_OFS, 32'h0000_0000);
    rd(pvw_pkg::XOFS_OFS, 32'h0000_0000);
    rd(12'h100, 32'h0000_0000);
    wb(1'h1, pvw_pkg::CTL_OFS, 32'hffff_ffff);
    rd(pvw_pkg::CTL_OFS, pvw_pkg::CTL_MASK);
    wb(1'h1, pvw_pkg::BASE_OFS, 32'hffff_ffff);
    rd(pvw_pkg::BASE_OFS, pvw_pkg::ADDR_MASK);
    $display("register test done");
    wb(1'h1, pvw_pkg::CTL_OFS, 32'hc042_4100);
    wb(1'h1, pvw_pkg::BASE_OFS, 32'h0001_0000);
    wb(1'h1, pvw_pkg::BOUND_OFS, 32'h0001_2000);
    wb(1'h1, pvw_pkg::XOFS_OFS, 32'h1000_0000);
    s(32'h0000_fffc, 1'h0, 1'h1, 1'h0);
    s(32'h0001_0004, 1'h0, 1'h1, 1'h1);
    pop(32'h1001_0004, 32'h0000_026b);
    s(32'h0001_1ffc, 1'h0, 1'h0, 1'h1);
    pop(32'h1001_1ffc, 32'h0000_0268);
    s(32'h0001_2000, 1'h0, 1'h1, 1'h0);
    s(32'h0001_0010, 1'h1, 1'h1, 1'h0);
    $display("decode test done");
    wb(1'h1, pvw_pkg::CTL_OFS, 32'hc0c1_1101);
    wb(1'h1, pvw_pkg::BOUND_OFS, 32'h0000_0000);
    wb(1'h1, pvw_pkg::XOFS_OFS, 32'hf000_0000);
    s(32'hffff_f008, 1'h1, 1'h1, 1'h1);
    pop(32'hefff_f008, 32'h0000_01d5);
    s(32'h0000_f000, 1'h1, 1'h0, 1'h0);
    s(32'h0001_0010, 1'h0, 1'h1, 1'h0);
    $display("io test done");
    wb(1'h1, pvw_pkg::CTL_OFS, 32'h8040_0100);
    s(32'h0002_1000, 1'h0, 1'h1, 1'h1);
    s(32'h0002_2000, 1'h0, 1'h1, 1'h1);
    fork
      s(32'h0002_3000, 1'h0, 1'h1, 1'h1);
    join_none
    repeat (3) @(negedge clk_i);
    chk({30'h0, pci_ready_o, pci_claim_o}, 32'h0000_0001);
    pop(32'hf002_1000, 32'h0000_0041);
    pop(32'hf002_2000, 32'h0000_0041);
    pop(32'hf002_3000, 32'h0000_0041);
    wb(1'h1, pvw_pkg::CTL_OFS, 32'h8043_0000);
    s(32'h0002_1000, 1'h0, 1'h1, 1'h0);
    wb(1'h1, pvw_pkg::CTL_OFS, 32'h0040_0100);
    s(32'h0002_1000, 1'h0, 1'h1, 1'h0);
    // six claims and seven misses since reset
    rd(pvw_pkg::STAT_OFS, 32'h0007_0006);
    wb(1'h1, pvw_pkg::STAT_OFS, 32'h0000_0000);
    rd(pvw_pkg::STAT_OFS, 32'h0000_0000);
    $display("buffer test done");
    print_verdict();
  end
endmodule : tb_top
